// ---- hw/windowed_watchdog_service.sv ----
// Windowed watchdog with service key register, APB registers and interrupt
//
// Functional notes
// - Service register always reads zero.
// - Rate 000 disables watchdog; service writes are ignored.
// - Enabled, any service value but 55h or AAh requests reset.
// - 55h then AAh restarts timeout; other accesses between are harmless.
// - Counter reaching selected timeout without service requests reset.
// - Normal mode tolerates repeated 55h or repeated AAh writes.
// - Windowed mode: write in first 75% of period requests reset.
// - Windowed mode: 55h repeatable, AAh after 55h restarts the period.
// - Counter runs on reference clock; three-bit rate picks seven periods.
// - Stop mode halts counter unless stop-run bit is set.
// - Wait mode keeps counter running while wait-stop bit is clear.
// - Secured part in special single-chip mode forces longest rate.
// - Rate and window enable load from option byte after reset.
// - Initial rate is inverse of option byte bits 2:0.
// - Initial window enable is inverse of option byte bit 3.
// - Option byte is fetched from global address 03FF0Eh at reset.
// - Rates 001..111 give 2^6,8,10,12,14,15,16 cycles; 000 disables.
// - Writing nonzero rate enables counter and starts fresh period.
`timescale 1ns/1ps
module windowed_watchdog_service
(
   // Clock and reset
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   // APB slave
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [7:0]           paddr,
   input  wire logic [31:0]          pwdata,
   output logic      [31:0]          prdata,
   output logic                      pready,
   output logic                      pslverr,
   // Asynchronous pins: reference clock, power modes, straps
   input  wire wdt_pkg::mode_pins_s  mode_pins,
   // Option byte fetch from nonvolatile memory
   output logic                      nv_req,
   output logic      [23:0]          nv_addr,
   input  wire logic                 nv_ack,
   input  wire logic [7:0]           nv_data,
   // Reset request and interrupt
   output logic                      wd_reset_req,
   output logic                      irq
);

   wdt_pkg::wdt_state_s s_r;
   wdt_pkg::wdt_state_s s_nxt;
   wdt_pkg::mode_pins_s pins_s;

   logic                      setup_ph;
   logic                      wr_acc;
   logic                      addr_hit;
   logic [31:0]               rd_val;
   logic                      enabled;
   logic [4:0]                rate_exp;
   logic [wdt_pkg::CNT_W-1:0] period_last;
   logic [wdt_pkg::CNT_W-1:0] win_start;
   logic [wdt_pkg::CNT_W-1:0] cnt_inc;
   logic                      in_window;
   logic                      tick;
   logic                      frozen;
   logic                      clear_hold;
   logic [7:0]                key;

   // Period arithmetic below is written for a 17-bit count
   generate
      if (wdt_pkg::CNT_W != 17)
      begin : g_bad_width
         $error("watchdog count width must be 17 bits");
      end
   endgenerate

   // Pins pass two flops before any logic looks at them
   level_sync
   #(
      .W      ($bits(wdt_pkg::mode_pins_s)),
      .STAGES (wdt_pkg::SYNC_STAGES)
   )
   u_pin_sync
   (
      .pclk    (pclk),
      .presetn (presetn),
      .din     (mode_pins),
      .dout    (pins_s)
   );

   always_comb
   begin
      case (s_r.rate)
         3'h1:    rate_exp = 5'd6;
         3'h2:    rate_exp = 5'd8;
         3'h3:    rate_exp = 5'd10;
         3'h4:    rate_exp = 5'd12;
         3'h5:    rate_exp = 5'd14;
         3'h6:    rate_exp = 5'd15;
         3'h7:    rate_exp = 5'd16;
         default: rate_exp = 5'd6;
      endcase
   end

   // Period end and window start in reference cycles
   assign period_last = (17'h00001 << rate_exp) - 17'h00001;
   // Window is the last quarter of the period
   assign win_start = (17'h00001 << rate_exp) - (17'h00001 << (rate_exp - 5'd2));
   assign cnt_inc   = s_r.cnt + 17'h00001;
   assign in_window = (s_r.cnt >= win_start);

   // Disabled while rate is 000 or before the option byte is in
   assign enabled = (s_r.rate != wdt_pkg::RATE_OFF) && (s_r.cfg == wdt_pkg::CFG_RUN);

   // One count per rising edge of the synchronised reference clock
   assign tick = pins_s.ref_clk & ~s_r.ref_d;

   // Stop mode freezes the count unless stop-run is set
   assign frozen = pins_s.stop_mode & ~s_r.stop_run_bit;

   // Wait mode with wait-stop set holds the counter cleared
   assign clear_hold = pins_s.wait_mode & s_r.wait_stop_bit;

   assign key      = pwdata[7:0];
   assign setup_ph = psel & ~penable;
   assign wr_acc   = psel & penable & pwrite;

   always_comb
   begin
      case (paddr)
         wdt_pkg::CTRL_ADDR,
         wdt_pkg::STATE_ADDR,
         wdt_pkg::IRQ_STS_ADDR,
         wdt_pkg::IRQ_MASK_ADDR,
         wdt_pkg::OPTION_ADDR,
         wdt_pkg::SERVICE_ADDR: addr_hit = 1'b1;
         default:               addr_hit = 1'b0;
      endcase
   end

   // Read mux, sampled during the setup phase
   always_comb
   begin
      rd_val = 32'h00000000;
      case (paddr)
         wdt_pkg::CTRL_ADDR:
         begin
            rd_val[wdt_pkg::CTRL_RATE_LSB +: 3] = s_r.rate;
            rd_val[wdt_pkg::CTRL_STOP_BIT]      = s_r.stop_run_bit;
            rd_val[wdt_pkg::CTRL_WAIT_BIT]      = s_r.wait_stop_bit;
            rd_val[wdt_pkg::CTRL_WIN_BIT]       = s_r.window_enable;
         end
         wdt_pkg::STATE_ADDR:
         begin
            rd_val[wdt_pkg::CNT_W-1:0]           = s_r.cnt;
            rd_val[wdt_pkg::STATE_WIN_BIT]       = in_window;
            rd_val[wdt_pkg::STATE_ARMED_BIT]     = s_r.armed;
            rd_val[wdt_pkg::STATE_LOADED_BIT]    = (s_r.cfg == wdt_pkg::CFG_RUN);
         end
         wdt_pkg::IRQ_STS_ADDR:  rd_val[wdt_pkg::IRQ_N-1:0] = s_r.irq_sts;
         wdt_pkg::IRQ_MASK_ADDR: rd_val[wdt_pkg::IRQ_N-1:0] = s_r.irq_mask;
         wdt_pkg::OPTION_ADDR:   rd_val[7:0] = s_r.option;
         wdt_pkg::SERVICE_ADDR:  rd_val = 32'h00000000;
         default:                rd_val = 32'h00000000;
      endcase
   end

   always_comb
   begin
      logic [wdt_pkg::IRQ_N-1:0] ev;
      logic [wdt_pkg::IRQ_N-1:0] clr;
      logic                      restart;
      logic                      fire;

      ev      = '0;
      clr     = '0;
      restart = 1'b0;
      fire    = 1'b0;
      s_nxt   = s_r;

      s_nxt.ref_d     = pins_s.ref_clk;
      s_nxt.reset_req = 1'b0;

      if (setup_ph && !pwrite)
         s_nxt.prdata = rd_val;

      // Configuration load after reset release
      case (s_r.cfg)
         wdt_pkg::CFG_IDLE:
         begin
            s_nxt.cfg = wdt_pkg::CFG_FETCH;
         end
         wdt_pkg::CFG_FETCH:
         begin
            // Option byte fetched during the reset sequence
            if (nv_ack)
            begin
               s_nxt.option = nv_data;
               // Rate and window taken from the option byte
               // Rate is the inverted low three bits
               s_nxt.rate = ~nv_data[2:0];
               // Window enable is the inverted bit 3
               s_nxt.window_enable = ~nv_data[wdt_pkg::OPT_WIN_BIT];
               // Secured special single-chip start forces longest rate
               if (pins_s.secured && pins_s.special_mode)
                  s_nxt.rate = wdt_pkg::RATE_LONGEST;
               s_nxt.cnt   = '0;
               s_nxt.armed = 1'b0;
               s_nxt.cfg   = wdt_pkg::CFG_RUN;
            end
         end
         wdt_pkg::CFG_RUN:
         begin
            s_nxt.cfg = wdt_pkg::CFG_RUN;
         end
         default:
         begin
            s_nxt.cfg = wdt_pkg::CFG_IDLE;
         end
      endcase

      // Counting; a clear hold in wait mode beats ticks and the timeout, but not service-write reset requests
      if (enabled)
      begin
         if (clear_hold)
            s_nxt.cnt = '0;
         else if (tick && !frozen)
         begin
            if (s_r.cnt == period_last)
               fire = 1'b1;
            else
            begin
               s_nxt.cnt = cnt_inc;
               if (s_r.window_enable && cnt_inc == win_start)
                  ev[wdt_pkg::IRQ_WINDOW_BIT] = 1'b1;
            end
         end
      end

      if (wr_acc)
      begin
         case (paddr)
            wdt_pkg::CTRL_ADDR:
            begin
               s_nxt.stop_run_bit  = pwdata[wdt_pkg::CTRL_STOP_BIT];
               s_nxt.wait_stop_bit = pwdata[wdt_pkg::CTRL_WAIT_BIT];
               s_nxt.window_enable = pwdata[wdt_pkg::CTRL_WIN_BIT];
               // Nonzero rate enables and restarts; 000 leaves rate alone
               if (pwdata[wdt_pkg::CTRL_RATE_LSB +: 3] != wdt_pkg::RATE_OFF)
               begin
                  s_nxt.rate = pwdata[wdt_pkg::CTRL_RATE_LSB +: 3];
                  restart    = 1'b1;
               end
            end
            wdt_pkg::IRQ_STS_ADDR:  clr = pwdata[wdt_pkg::IRQ_N-1:0];
            wdt_pkg::IRQ_MASK_ADDR: s_nxt.irq_mask = pwdata[wdt_pkg::IRQ_N-1:0];
            wdt_pkg::SERVICE_ADDR:
            begin
               if (enabled)
               begin
                  if (s_r.window_enable && !in_window)
                     fire = 1'b1;
                  // Repeated first keys simply stay armed
                  else if (key == wdt_pkg::KEY_FIRST)
                     s_nxt.armed = 1'b1;
                  else if (key == wdt_pkg::KEY_SECOND)
                  begin
                     // Second key after first key restarts the period
                     // Restart puts the next write before the window
                     if (s_r.armed)
                     begin
                        restart                      = 1'b1;
                        ev[wdt_pkg::IRQ_RESTART_BIT] = 1'b1;
                     end
                  end
                  else
                     fire = 1'b1;
               end
            end
            default:
            begin
               s_nxt.armed = s_r.armed;
            end
         endcase
      end

      if (restart)
      begin
         s_nxt.cnt   = '0;
         s_nxt.armed = 1'b0;
      end

      // One-cycle registered request; count restarts so it fires once
      if (fire)
      begin
         s_nxt.reset_req             = 1'b1;
         s_nxt.cnt                   = '0;
         s_nxt.armed                 = 1'b0;
         ev[wdt_pkg::IRQ_RESET_BIT]  = 1'b1;
      end

      // A new event beats a software clear in the same cycle
      s_nxt.irq_sts = (s_r.irq_sts & ~clr) | ev;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s_r.cfg           <= wdt_pkg::CFG_IDLE;
         s_r.option        <= wdt_pkg::OPT_RST;
         s_r.rate          <= wdt_pkg::RATE_OFF;
         s_r.window_enable <= 1'b0;
         s_r.stop_run_bit  <= 1'b0;
         s_r.wait_stop_bit <= 1'b0;
         s_r.cnt           <= '0;
         s_r.armed         <= 1'b0;
         s_r.ref_d         <= 1'b0;
         s_r.reset_req     <= 1'b0;
         s_r.irq_sts       <= '0;
         s_r.irq_mask      <= wdt_pkg::MASK_RST;
         s_r.prdata        <= 32'h00000000;
      end
      else
         s_r <= s_nxt;
   end

   // Zero wait states keep the service path deterministic for software
   assign pready       = 1'b1;
   assign pslverr      = psel & penable & ~addr_hit;
   assign prdata       = s_r.prdata;
   assign nv_req       = (s_r.cfg == wdt_pkg::CFG_FETCH);
   assign nv_addr      = wdt_pkg::NV_OPT_ADDR;
   assign wd_reset_req = s_r.reset_req;
   assign irq          = |(s_r.irq_sts & s_r.irq_mask);

endmodule

// ---- hw/wdt_pkg.sv ----
// Shared constants, states and carriers of the windowed watchdog
package wdt_pkg;

   // Register byte addresses (service register sits at index 0x3F)
   localparam logic [7:0] CTRL_ADDR     = 8'h00;
   localparam logic [7:0] STATE_ADDR    = 8'h04;
   localparam logic [7:0] IRQ_STS_ADDR  = 8'h08;
   localparam logic [7:0] IRQ_MASK_ADDR = 8'h0C;
   localparam logic [7:0] OPTION_ADDR   = 8'h10;
   localparam logic [5:0] SERVICE_IDX   = 6'h3F;
   localparam logic [7:0] SERVICE_ADDR  = {SERVICE_IDX, 2'b00};

   // Control register fields
   localparam int unsigned CTRL_RATE_LSB  = 0;
   localparam int unsigned CTRL_STOP_BIT  = 3;
   localparam int unsigned CTRL_WAIT_BIT  = 4;
   localparam int unsigned CTRL_WIN_BIT   = 7;

   // State register fields (count sits in the low bits)
   localparam int unsigned STATE_WIN_BIT    = 20;
   localparam int unsigned STATE_ARMED_BIT  = 21;
   localparam int unsigned STATE_LOADED_BIT = 22;

   // Interrupt status and mask layout
   localparam int unsigned IRQ_N           = 3;
   localparam int unsigned IRQ_RESTART_BIT = 0;
   localparam int unsigned IRQ_WINDOW_BIT  = 1;
   localparam int unsigned IRQ_RESET_BIT   = 2;

   // Option byte fields
   localparam int unsigned OPT_WIN_BIT = 3;

   // Service keys, rate codes and the option byte location
   localparam logic [7:0]  KEY_FIRST     = 8'h55;
   localparam logic [7:0]  KEY_SECOND    = 8'hAA;
   localparam logic [2:0]  RATE_OFF      = 3'h0;
   localparam logic [2:0]  RATE_LONGEST  = 3'h7;
   localparam logic [23:0] NV_OPT_ADDR   = 24'h03FF0E;

   // Sizes and reset values
   localparam int unsigned CNT_W        = 17;
   localparam int unsigned SYNC_STAGES  = 2;
   localparam logic [7:0]  OPT_RST      = 8'hFF;
   localparam logic [IRQ_N-1:0] MASK_RST = 3'h0;

   typedef enum logic [2:0]
   {
      CFG_IDLE  = 3'b001,
      CFG_FETCH = 3'b010,
      CFG_RUN   = 3'b100
   } cfg_state_e;

   // Pins arriving from outside the pclk domain
   typedef struct packed
   {
      logic ref_clk;
      logic stop_mode;
      logic wait_mode;
      logic secured;
      logic special_mode;
   } mode_pins_s;

   // Whole state of the watchdog top
   typedef struct packed
   {
      cfg_state_e       cfg;
      logic [7:0]       option;
      logic [2:0]       rate;
      logic             window_enable;
      logic             stop_run_bit;
      logic             wait_stop_bit;
      logic [CNT_W-1:0] cnt;
      logic             armed;
      logic             ref_d;
      logic             reset_req;
      logic [IRQ_N-1:0] irq_sts;
      logic [IRQ_N-1:0] irq_mask;
      logic [31:0]      prdata;
   } wdt_state_s;

endpackage

// ---- hw/level_sync.sv ----
// Multi-bit two-stage level synchroniser for asynchronous pins
`timescale 1ns/1ps
module level_sync
#(
   parameter int unsigned W      = 1,
   parameter int unsigned STAGES = 2
)
(
   // Clock and reset
   input  wire logic         pclk,
   input  wire logic         presetn,
   // Raw and synchronised levels
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);

   logic [STAGES*W-1:0] chain_r;
   logic [STAGES*W-1:0] chain_nxt;

   generate
      if (W < 1 || STAGES < 2)
      begin : g_bad
         $error("level_sync needs W >= 1 and STAGES >= 2");
      end
   endgenerate

   // Only the last stage is visible; earlier stages feed the next stage only
   always_comb
   begin
      chain_nxt = {chain_r[(STAGES-1)*W-1:0], din};
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         chain_r <= '0;
      else
         chain_r <= chain_nxt;
   end

   assign dout = chain_r[STAGES*W-1 -: W];

endmodule

// ---- bench/wdt_checker.sv ----
// Port-level assertions of the windowed watchdog
`timescale 1ns/1ps
module wdt_checker
(
   // Clock and reset
   input wire logic                pclk,
   input wire logic                presetn,
   // APB slave side
   input wire logic                psel,
   input wire logic                penable,
   input wire logic                pwrite,
   input wire logic [7:0]          paddr,
   input wire logic [31:0]         pwdata,
   input wire logic [31:0]         prdata,
   input wire logic                pready,
   input wire logic                pslverr,
   // Pins, option fetch, outputs
   input wire wdt_pkg::mode_pins_s mode_pins,
   input wire logic                nv_req,
   input wire logic [23:0]         nv_addr,
   input wire logic                nv_ack,
   input wire logic [7:0]          nv_data,
   input wire logic                wd_reset_req,
   input wire logic                irq
);
   logic acc;
   logic mapped;
   assign acc = psel & penable;
   assign mapped = paddr inside {wdt_pkg::CTRL_ADDR, wdt_pkg::STATE_ADDR, wdt_pkg::IRQ_STS_ADDR,
                                 wdt_pkg::IRQ_MASK_ADDR, wdt_pkg::OPTION_ADDR,
                                 wdt_pkg::SERVICE_ADDR};
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_pulse; wd_reset_req |=> !wd_reset_req; endproperty
   a_pulse: assert property (p_pulse) else $error("reset request longer than one cycle");
   property p_svc_zero;
      acc && !pwrite && paddr == wdt_pkg::SERVICE_ADDR |-> prdata == 32'h0;
   endproperty
   a_svc_zero: assert property (p_svc_zero) else $error("service read not zero");
   property p_unmapped; acc && !mapped |-> pslverr; endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped access without error");
   property p_mapped; acc && mapped |-> !pslverr; endproperty
   a_mapped: assert property (p_mapped) else $error("mapped access flagged as error");
   property p_nv_addr; nv_req |-> nv_addr == wdt_pkg::NV_OPT_ADDR; endproperty
   a_nv_addr: assert property (p_nv_addr) else $error("option fetch address wrong");
   property p_nv_done; nv_req && nv_ack |=> !nv_req; endproperty
   a_nv_done: assert property (p_nv_done) else $error("option request held after ack");
   property p_quiet_load; nv_req |-> !wd_reset_req; endproperty
   a_quiet_load: assert property (p_quiet_load) else $error("reset request before load");
   property p_nv_start; $rose(presetn) |-> ##[0:2] nv_req; endproperty
   a_nv_start: assert property (p_nv_start) else $error("no option fetch after reset");
   c_req: cover property (wd_reset_req);
   c_load: cover property (nv_req && nv_ack);
   c_irq: cover property (irq);
endmodule

bind windowed_watchdog_service wdt_checker i_wdt_checker
(
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .mode_pins(mode_pins), .nv_req(nv_req), .nv_addr(nv_addr), .nv_ack(nv_ack),
   .nv_data(nv_data), .wd_reset_req(wd_reset_req), .irq(irq)
);

// ---- bench/windowed_watchdog_service_tb.sv ----
// Self-checking bench of the windowed watchdog
`timescale 1ns/1ps
module windowed_watchdog_service_tb;
   logic                pclk;
   logic                presetn;
   logic                psel;
   logic                penable;
   logic                pwrite;
   logic [7:0]          paddr;
   logic [31:0]         pwdata;
   logic [31:0]         prdata;
   logic                pready;
   logic                pslverr;
   wdt_pkg::mode_pins_s mode_pins;
   logic                nv_req;
   logic [23:0]         nv_addr;
   logic                nv_ack;
   logic [7:0]          nv_data;
   logic                wd_reset_req;
   logic                irq;
   logic [7:0]          nv_byte;
   logic                last_err;
   int                  num_errors;
   int                  checks_done;
   int                  cyc;

   windowed_watchdog_service i_windowed_watchdog_service
   (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .mode_pins(mode_pins), .nv_req(nv_req), .nv_addr(nv_addr), .nv_ack(nv_ack),
      .nv_data(nv_data), .wd_reset_req(wd_reset_req), .irq(irq)
   );

   initial
   begin
      pclk = 1'h0;
      forever #2.5 pclk = ~pclk;
   end

   // Reference clock at a quarter of pclk, well under the pclk/2 limit
   always @(posedge pclk)
   begin
      cyc <= cyc + 1;
      if (cyc % 2 == 1)
         mode_pins.ref_clk <= ~mode_pins.ref_clk;
      nv_ack  <= nv_req;
      nv_data <= nv_byte;
      if (cyc == 60000)
      begin
         num_errors = num_errors + 1;
         complete_run();
      end
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         num_errors++;
         $display("BAD at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      @(posedge pclk);
      psel    <= 1'h1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'h1;
      // Only the bench timeout ends a wait for pready
      do
      begin
         @(posedge pclk);
      end
      while (pready !== 1'h1);
      q        = prdata;
      last_err = pslverr;
      psel    <= 1'h0;
      penable <= 1'h0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      apb(1'h1, a, d, q);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] q);
      apb(1'h0, a, 32'h0, q);
   endtask

   task automatic wait_req(input int lim, output int n);
      n = 0;
      while (wd_reset_req !== 1'h1 && n < lim)
      begin
         @(posedge pclk);
         n++;
      end
   endtask

   task automatic boot(input logic [7:0] nvb, input logic sec, input logic [31:0] exp_ctrl);
      logic [31:0] q;
      int          n;
      n = 0;
      @(posedge pclk);
      presetn                <= 1'h0;
      nv_byte                <= nvb;
      mode_pins.secured      <= sec;
      mode_pins.special_mode <= sec;
      repeat (20) @(posedge pclk);
      presetn <= 1'h1;
      do
      begin
         rd(wdt_pkg::STATE_ADDR, q);
         n++;
      end
      while (q[wdt_pkg::STATE_LOADED_BIT] !== 1'h1 && n < 10);
      rd(wdt_pkg::OPTION_ADDR, q);
      check(q, {24'h0, nvb});
      rd(wdt_pkg::CTRL_ADDR, q);
      check(q & 32'h87, exp_ctrl);
   endtask

   task automatic t_disabled();
      logic [31:0] q;
      int          n;
      boot(8'h07, 1'h0, 32'h80);
      rd(wdt_pkg::SERVICE_ADDR, q);
      check(q, 32'h0);
      rd(8'h20, q);
      check({31'h0, last_err}, 32'h1);
      check(q, 32'h0);
      wr(wdt_pkg::SERVICE_ADDR, 32'h12);
      wait_req(20, n);
      check(n, 20);
      $display("test disabled finished");
   endtask

   task automatic t_normal();
      logic [31:0] q;
      int          n;
      // Unforced this byte would give rate 000, so the forcing is visible
      boot(8'hF7, 1'h1, 32'h87);
      boot(8'hFE, 1'h0, 32'h01);
      wr(wdt_pkg::CTRL_ADDR, 32'h01);
      wr(wdt_pkg::SERVICE_ADDR, 32'h55);
      rd(wdt_pkg::SERVICE_ADDR, q);
      check(q, 32'h0);
      wr(wdt_pkg::SERVICE_ADDR, 32'h55);
      rd(wdt_pkg::CTRL_ADDR, q);
      wr(wdt_pkg::SERVICE_ADDR, 32'hAA);
      wr(wdt_pkg::SERVICE_ADDR, 32'hAA);
      wait_req(40, n);
      check(n, 40);
      rd(wdt_pkg::IRQ_STS_ADDR, q);
      check(q & 32'h1, 32'h1);
      wr(wdt_pkg::IRQ_MASK_ADDR, 32'h1);
      repeat (2) @(posedge pclk);
      check({31'h0, irq}, 32'h1);
      wr(wdt_pkg::IRQ_STS_ADDR, 32'h1);
      repeat (2) @(posedge pclk);
      check({31'h0, irq}, 32'h0);
      wr(wdt_pkg::SERVICE_ADDR, 32'h3C);
      wait_req(3, n);
      check(n, 1);
      $display("test normal finished");
   endtask

   task automatic t_timeout();
      int exps[3];
      int n;
      int i;
      exps = '{6, 8, 10};
      for (i = 0; i < 3; i++)
      begin
         // Fresh period from the rate write; ref_clk ticks every 4 pclk
         wr(wdt_pkg::CTRL_ADDR, i + 1);
         wait_req(5000, n);
         check(n > 4 * (1 << exps[i]) - 12 && n < 4 * (1 << exps[i]) + 12, 32'h1);
      end
      $display("test timeout finished");
   endtask

   task automatic t_window();
      logic [31:0] q;
      int          n;
      wr(wdt_pkg::CTRL_ADDR, 32'h81);
      wr(wdt_pkg::SERVICE_ADDR, 32'h55);
      wait_req(3, n);
      check(n, 1);
      repeat (210) @(posedge pclk);
      wr(wdt_pkg::SERVICE_ADDR, 32'h55);
      wr(wdt_pkg::SERVICE_ADDR, 32'h55);
      wr(wdt_pkg::SERVICE_ADDR, 32'hAA);
      wait_req(30, n);
      check(n, 30);
      // Window-opened and reset-requested status bits
      rd(wdt_pkg::IRQ_STS_ADDR, q);
      check(q & 32'h6, 32'h6);
      wr(wdt_pkg::SERVICE_ADDR, 32'h55);
      wait_req(3, n);
      check(n, 1);
      $display("test window finished");
   endtask

   // Rate 001 is 64 ticks of ref_clk, 256 pclk cycles
   task automatic t_modes();
      logic [31:0] q;
      int          n;
      @(posedge pclk);
      mode_pins.stop_mode <= 1'h1;
      wr(wdt_pkg::CTRL_ADDR, 32'h01);
      wait_req(400, n);
      check(n, 400);
      rd(wdt_pkg::STATE_ADDR, q);
      check(q & 32'h0001FFFF, 32'h0);
      wr(wdt_pkg::CTRL_ADDR, 32'h09);
      wait_req(400, n);
      check(n > 244 && n < 268, 32'h1);
      @(posedge pclk);
      mode_pins.stop_mode <= 1'h0;
      mode_pins.wait_mode <= 1'h1;
      wr(wdt_pkg::CTRL_ADDR, 32'h01);
      wait_req(400, n);
      check(n > 244 && n < 268, 32'h1);
      wr(wdt_pkg::CTRL_ADDR, 32'h11);
      wait_req(400, n);
      check(n, 400);
      rd(wdt_pkg::STATE_ADDR, q);
      check(q & 32'h0001FFFF, 32'h0);
      @(posedge pclk);
      mode_pins.wait_mode <= 1'h0;
      $display("test modes finished");
   endtask

   task automatic complete_run();
      $display("mismatches %0d comparisons %0d", num_errors, checks_done);
      if (num_errors == 0 && checks_done > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   initial
   begin
      presetn     = 1'h0;
      psel        = 1'h0;
      penable     = 1'h0;
      pwrite      = 1'h0;
      paddr       = 8'h00;
      pwdata      = 32'h0;
      mode_pins   = '0;
      nv_ack      = 1'h0;
      nv_data     = 8'h00;
      nv_byte     = 8'h00;
      last_err    = 1'h0;
      num_errors  = 0;
      checks_done = 0;
      cyc         = 0;
      t_disabled();
      t_normal();
      t_timeout();
      t_window();
      t_modes();
      complete_run();
   end
endmodule
